/* triple_timer_event_counter_tb.sv */
// self-checking bench for the triple timer block
`timescale 1ns/100ps
`default_nettype none
module triple_timer_event_counter_tb;
  logic mclk_i = 0, reset_i = 1, rd = 0, wr = 0, lf = 0, idle = 0, go = 0;
  logic [5:0] adr = 0;
  logic [31:0] wd = 0, rdata, q;
  logic [3:0] be = 4'h1;
  logic [7:0] np = 0, wp = 4;
  logic [2:0] irq;
  logic wait_o, pin, busy;
  int fails = 0, checked = 0, n;
  int irqs = 0;
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) irqs <= irqs + int'(irq[0]) + int'(irq[1]);
  always begin
    repeat (20) @(posedge mclk_i);
    lf <= ~lf;
  end
  tte_timers dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(1'b1), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .lf_clk_i(lf),
    .timer0_ext_pin_i(pin), .timer1_ext_pin_i(pin), .irq_o(irq));
  tte_pin_src src_u (.mclk_i(mclk_i), .idle_i(idle), .start_i(go), .n_i(np), .w_i(wp),
    .pin_o(pin), .busy_o(busy));
  task stop_test;
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      fails++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    rd <= !w; wr <= w; adr <= a; wd <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    if (wait_o !== 1'b0) begin
      fails++;
      $display("Error at %0t: bus stuck got %h expected %h", $time, wait_o, 1'b0);
    end
    q = rdata;
    rd <= 0; wr <= 0;
  endtask
  task ld(input int t, input logic [15:0] v);
    bus(1, 6'(t * 16), v[7:0]);
    bus(1, 6'(t * 16 + 4), v[15:8]);
  endtask
  task rd16(input int t, output logic [31:0] v);
    bus(0, 6'(t * 16 + 4), 8'h00);
    v = q << 8;
    bus(0, 6'(t * 16), 8'h00);
    v = v | q;
  endtask
  task t_regs;
    bus(0, 6'h28, 8'h00); chk(q, 0, 0);
    ld(2, 16'habcd); bus(1, 6'h20, 8'h11); rd16(2, q); chk(q, 'habcd, 'habcd);
    ld(2, 16'h5a3c); rd16(2, q); chk(q, 'h5a3c, 'h5a3c);
    bus(0, 6'h30, 8'h00); chk(q, 0, 0);
    be <= 4'h0; bus(1, 6'h28, 8'h90); be <= 4'h1;
    bus(0, 6'h28, 8'h00); chk(q, 0, 0);
    $display("test regs done");
  endtask
  task t_overflow;
    ld(2, 16'hfff0); bus(1, 6'h28, 8'h90);
    for (n = 0; n < 100 && irq[2] !== 1'b1; n++) @(posedge mclk_i);
    chk(n, 10, 30);
    @(posedge mclk_i); chk(irq[2], 0, 0);
    ld(2, 16'h1234); bus(0, 6'h24, 8'h00); chk(q, 'hff, 'hff);
    for (n = 0; n < 100 && irq[2] !== 1'b1; n++) @(posedge mclk_i);
    bus(1, 6'h28, 8'h00); rd16(2, q); chk(q, 'h1234, 'h1234 + 12);
    $display("test overflow done");
  endtask
  task t_clocks;
    ld(0, 0); ld(1, 0);
    bus(1, 6'h08, 8'h90); bus(1, 6'h18, 8'h90);
    repeat (400) @(posedge mclk_i);
    bus(1, 6'h08, 8'h00); bus(1, 6'h18, 8'h00);
    rd16(0, q); chk(q, 98, 106);
    rd16(1, q); chk(q, 9, 12);
    $display("test clocks done");
  endtask
  task pulses(input logic [7:0] cnt, input logic [7:0] w);
    np <= cnt; wp <= w; go <= 1;
    @(posedge mclk_i);
    go <= 0;
    @(posedge mclk_i);
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge mclk_i);
    if (busy !== 1'b0) begin
      fails++;
      $display("Error at %0t: pulse source stuck got %h expected %h", $time, busy, 1'b0);
    end
    repeat (8) @(posedge mclk_i);
  endtask
  task t_event;
    for (int t = 0; t < 2; t++) begin
      for (int e = 0; e < 2; e++) begin
        ld(t, 16'hfffe); bus(1, 6'(t * 16 + 8), 8'(8'h50 | (e * 8)));
        pulses(5, 6);
        bus(1, 6'(t * 16 + 8), 8'h00); rd16(t, q); chk(q, 'hffff, 'hffff);
      end
    end
    chk(irqs, 8, 8);
    $display("test event done");
  endtask
  task t_width;
    ld(0, 0); bus(1, 6'h08, 8'hd8);
    pulses(1, 80); rd16(0, q); chk(q, 18, 22);
    bus(0, 6'h08, 8'h00); chk(q, 'hc8, 'hc8);
    idle <= 1;
    repeat (8) @(posedge mclk_i);
    ld(0, 0); bus(1, 6'h08, 8'hd0);
    pulses(1, 80); rd16(0, q); chk(q, 18, 22);
    bus(0, 6'h08, 8'h00); chk(q, 'hc0, 'hc0);
    $display("test width done");
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 0;
    t_regs;
    t_overflow;
    t_clocks;
    t_event;
    t_width;
    stop_test;
  end
  initial begin
    repeat (30000) @(posedge mclk_i);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire

/* tte_pin_src.sv */
// pulse source model standing on the external timer pins
`timescale 1ns/100ps
`default_nettype none
module tte_pin_src (
  input  wire logic       mclk_i,
  input  wire logic       idle_i,
  input  wire logic       start_i,
  input  wire logic [7:0] n_i,
  input  wire logic [7:0] w_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic act_r = 1'b0;
  initial busy_o = 1'b0;
  // pin rests at its idle level between pulses, never at a stale value
  assign pin_o = act_r ^ idle_i;
  always begin
    @(posedge mclk_i);
    if (start_i) begin
      busy_o <= 1'b1;
      repeat (n_i) begin
        act_r <= 1'b1;
        repeat (w_i) @(posedge mclk_i);
        act_r <= 1'b0;
        repeat (w_i) @(posedge mclk_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tte_pkg.sv */
// constants and types for the triple timer/event counter block
// Overview of operation
// - three independent 16-bit counters, each counting upward only
// - timers 0 and 1: timer, event, pulse-width modes; timer 2 timer mode only
// - timer 0 internal clock is system clock divided by four, else its pin
// - timer 1 internal clock is the 32768Hz clock, else its pin
// - timer 2 counts the system clock only, no external input
// - event mode: each selected-polarity pin transition adds exactly one
// - count steps by one per tick; passing FFFFH overflows with a request
// - overflow reloads the preload value and counting simply continues
// - preload register has no power-on value until software writes it
// - with the timer off, a preload write also loads the count at once
// - with the timer running, new preload enters the count only at overflow
// - low byte write goes only to the hidden low-byte holding buffer
// - high byte write stores it and moves the held low byte alongside
// - high byte read captures the live low count byte into the buffer
// - low byte read returns the captured buffer, not the live count
// - control bits 7:6 select the mode; 11 is pulse-width measurement
// - control bit 4 is run: set counts, cleared stops
// - event mode: edge bit 3 low counts rising, high counts falling
// - pulse-width: count internal clock across the pulse, then run self-clears
package tte_pkg;
  localparam int          TTE_NUM_TIMERS = 3;
  localparam int          TTE_ADDR_W     = 6;
  localparam int          TTE_COUNT_W    = 16;
  // byte addresses: timer n at n*0x10, register word at offset below
  localparam logic [1:0]  TTE_REG_LOW    = 2'h0;
  localparam logic [1:0]  TTE_REG_HIGH   = 2'h1;
  localparam logic [1:0]  TTE_REG_CTL    = 2'h2;
  localparam logic [5:0]  TTE_OFS_LOW    = 6'h00;
  localparam logic [5:0]  TTE_OFS_HIGH   = 6'h04;
  localparam logic [5:0]  TTE_OFS_CTL    = 6'h08;
  localparam logic [5:0]  TTE_STRIDE     = 6'h10;
  // mode field encodings
  localparam logic [1:0]  TTE_MODE_OFF   = 2'h0;
  localparam logic [1:0]  TTE_MODE_EVENT = 2'h1;
  localparam logic [1:0]  TTE_MODE_TIMER = 2'h2;
  localparam logic [1:0]  TTE_MODE_PWM   = 2'h3;
  // clocking
  localparam int          TTE_SYS_DIV    = 4;
  localparam int          TTE_LF_HZ      = 32768;
  localparam int          TTE_MCLK_HZ    = 10000000;
  // values after reset, and the full count that overflows on the next tick
  localparam logic [7:0]  TTE_CTL_RST    = 8'h00;
  localparam logic [15:0] TTE_COUNT_RST  = 16'h0000;
  localparam logic [15:0] TTE_COUNT_FULL = 16'hffff;
  localparam logic [7:0]  TTE_HOLD_RST   = 8'h00;

  typedef struct packed {
    logic [1:0] mode;
    logic       rsv5;
    logic       run;
    logic       edge_sel;
    logic [2:0] rsv;
  } tte_ctl_type;
endpackage

/* tte_timers.sv */
// three 16-bit timer/event counters behind an avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
module tte_timers (
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        lf_clk_i,
  input  wire logic        timer0_ext_pin_i,
  input  wire logic        timer1_ext_pin_i,
  output logic      [2:0]  irq_o
);
  localparam int N = tte_pkg::TTE_NUM_TIMERS;

  // event polarity pick: sel low takes rising, high takes falling
  function automatic logic pick_edge(input logic rise, input logic fall, input logic sel);
    pick_edge = sel ? fall : rise;
  endfunction

  // synchronisers, stage 1 read only by stage 2
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_s3_r;
  logic       lf_s1_r;
  logic       lf_s2_r;
  logic       lf_s3_r;
  logic [1:0] pre_r;
  logic       ack_r;
  logic [31:0] rdata_r;

  tte_pkg::tte_ctl_type ctl_r     [N];
  logic [15:0]          count_r   [N];
  logic [15:0]          preload_r [N];
  logic [7:0]           hold_r    [N];
  logic [7:0]           rd_byte   [N];
  logic [N-1:0]         meas_r;
  logic [N-1:0]         irq_r;

  logic [N-1:0] p_rise;
  logic [N-1:0] p_fall;
  logic [N-1:0] int_tick;
  logic [N-1:0] tick;
  logic [N-1:0] ovf;
  logic [N-1:0] sel_t;
  logic [N-1:0] lo_wr;
  logic [N-1:0] hi_wr;
  logic [N-1:0] ctl_wr;
  logic [N-1:0] hi_rd;
  logic [N-1:0] pwm_start;
  logic [N-1:0] pwm_end;
  logic [N-1:0] evt;

  wire        req      = avs_read_i | avs_write_i;
  wire        rd_prep  = ce_i & avs_read_i & ~ack_r;
  wire        wr_acc   = ce_i & avs_write_i & ack_r & avs_byteenable_i[0];
  wire [1:0]  tsel     = avs_address_i[5:4];
  wire [1:0]  rsel     = avs_address_i[3:2];
  wire [7:0]  wbyte    = avs_writedata_i[7:0];
  wire        pre_tick = (pre_r == 2'(tte_pkg::TTE_SYS_DIV - 1));
  wire        lf_rise  = lf_s2_r & ~lf_s3_r;
  wire [7:0]  rd_mux   = (tsel == 2'h0) ? rd_byte[0] :
                         (tsel == 2'h1) ? rd_byte[1] :
                         (tsel == 2'h2) ? rd_byte[2] : 8'h00;

  // one wait cycle: data is fetched on the first edge, taken on the second
  assign avs_waitrequest_o = req & ~(ack_r & ce_i);
  assign avs_readdata_o    = rdata_r;
  assign irq_o             = irq_r;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
      lf_s1_r  <= 1'b0;
      lf_s2_r  <= 1'b0;
      lf_s3_r  <= 1'b0;
      pre_r    <= 2'h0;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else if (ce_i) begin
      pin_s1_r <= {timer1_ext_pin_i, timer0_ext_pin_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      lf_s1_r  <= lf_clk_i;
      lf_s2_r  <= lf_s1_r;
      lf_s3_r  <= lf_s2_r;
      pre_r    <= pre_r + 2'h1;
      ack_r    <= req & ~ack_r;
      if (rd_prep) begin
        rdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign int_tick[0] = pre_tick;
  assign int_tick[1] = lf_rise;
  assign int_tick[2] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_tmr
      if (i < 2) begin : g_pin
        assign p_rise[i] = pin_s2_r[i] & ~pin_s3_r[i];
        assign p_fall[i] = ~pin_s2_r[i] & pin_s3_r[i];
      end else begin : g_nopin
        assign p_rise[i] = 1'b0;
        assign p_fall[i] = 1'b0;
      end

      assign sel_t[i]  = (tsel == 2'(i));
      assign lo_wr[i]  = wr_acc & sel_t[i] & (rsel == tte_pkg::TTE_REG_LOW);
      assign hi_wr[i]  = wr_acc & sel_t[i] & (rsel == tte_pkg::TTE_REG_HIGH);
      assign ctl_wr[i] = wr_acc & sel_t[i] & (rsel == tte_pkg::TTE_REG_CTL);
      assign hi_rd[i]  = rd_prep & sel_t[i] & (rsel == tte_pkg::TTE_REG_HIGH);

      assign evt[i]       = pick_edge(p_rise[i], p_fall[i], ctl_r[i].edge_sel);
      assign pwm_start[i] = pick_edge(p_rise[i], p_fall[i], ~ctl_r[i].edge_sel);
      assign pwm_end[i]   = evt[i];

      // timer 2 only honours timer mode
      assign tick[i] = ctl_r[i].run &
                       (((ctl_r[i].mode == tte_pkg::TTE_MODE_TIMER) & int_tick[i]) |
                        ((i < 2) & (ctl_r[i].mode == tte_pkg::TTE_MODE_EVENT) & evt[i]) |
                        ((i < 2) & (ctl_r[i].mode == tte_pkg::TTE_MODE_PWM) &
                         meas_r[i] & int_tick[i]));
      assign ovf[i] = tick[i] & (count_r[i] == tte_pkg::TTE_COUNT_FULL);

      assign rd_byte[i] = (rsel == tte_pkg::TTE_REG_LOW)  ? hold_r[i] :
                          (rsel == tte_pkg::TTE_REG_HIGH) ? count_r[i][15:8] :
                          (rsel == tte_pkg::TTE_REG_CTL)  ? ctl_r[i] : 8'h00;

      // no reset: contents stay unknown until software writes them
      always_ff @(posedge mclk_i) begin
        if (ce_i && hi_wr[i]) begin
          preload_r[i] <= {wbyte, hold_r[i]};
        end
      end

      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          ctl_r[i]   <= tte_pkg::TTE_CTL_RST;
          count_r[i] <= tte_pkg::TTE_COUNT_RST;
          hold_r[i]  <= tte_pkg::TTE_HOLD_RST;
          meas_r[i]  <= 1'b0;
          irq_r[i]   <= 1'b0;
        end else if (ce_i) begin
          irq_r[i] <= ovf[i];
          if (lo_wr[i]) begin
            hold_r[i] <= wbyte;
          end else if (hi_rd[i]) begin
            hold_r[i] <= count_r[i][7:0];
          end
          // a write while stopped lands in the count; running waits for overflow
          if (hi_wr[i] && !ctl_r[i].run) begin
            count_r[i] <= {wbyte, hold_r[i]};
          end else if (ovf[i]) begin
            count_r[i] <= preload_r[i];
          end else if (tick[i]) begin
            count_r[i] <= count_r[i] + 16'h0001;
          end
          if (ctl_wr[i]) begin
            ctl_r[i] <= (i < 2) ? wbyte : {wbyte[7:4], 1'b0, 3'h0};
          end else if (meas_r[i] && pwm_end[i]) begin
            ctl_r[i].run <= 1'b0;
          end
          if (!ctl_r[i].run || ctl_r[i].mode != tte_pkg::TTE_MODE_PWM || i >= 2) begin
            meas_r[i] <= 1'b0;
          end else if (!meas_r[i] && pwm_start[i]) begin
            meas_r[i] <= 1'b1;
          end else if (meas_r[i] && pwm_end[i]) begin
            meas_r[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // checks on timer 0 and timer 2, plus the event step on timer 1
  a_ovf_irq_pulse: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ovf[0]) |=> (irq_o[0] ##1 (!irq_o[0] || $past(ovf[0]))))
    else $error("overflow did not give a one-cycle request");

  a_ovf_reload: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ovf[0] && !hi_wr[0]) |=> (count_r[0] == $past(preload_r[0])))
    else $error("overflow did not reload the preload value");

  a_count_step: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && tick[0] && !ovf[0] && !hi_wr[0]) |=> (count_r[0] == $past(count_r[0]) + 16'h0001))
    else $error("count did not advance by one");

  a_stopped_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!ctl_r[2].run && !hi_wr[2]) |=> $stable(count_r[2]))
    else $error("stopped timer changed its count");

  a_t2_every_clk: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ctl_r[2].run && ctl_r[2].mode == tte_pkg::TTE_MODE_TIMER && !hi_wr[2]
     && count_r[2] != tte_pkg::TTE_COUNT_FULL) |=> (count_r[2] == $past(count_r[2]) + 16'h0001))
    else $error("timer 2 missed a system clock");

  a_high_rd_cap: assert property (@(posedge mclk_i) disable iff (reset_i)
    hi_rd[0] |=> (hold_r[0] == $past(count_r[0][7:0])))
    else $error("high read did not capture the low byte");

  a_low_rd_buf: assert property (@(posedge mclk_i) disable iff (reset_i)
    (rd_prep && sel_t[0] && rsel == tte_pkg::TTE_REG_LOW)
      |=> (avs_readdata_o == {24'h00_0000, $past(hold_r[0])}) && !avs_waitrequest_o)
    else $error("low read did not return the held byte");

  a_off_copy: assert property (@(posedge mclk_i) disable iff (reset_i)
    (hi_wr[0] && !ctl_r[0].run) |=> (count_r[0] == {$past(wbyte), $past(hold_r[0])}))
    else $error("stopped preload write missed the count");

  a_pwm_autoclr: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && meas_r[0] && pwm_end[0] && !ctl_wr[0]) |=> (!ctl_r[0].run && !meas_r[0]))
    else $error("pulse end did not stop the timer");

  a_event_step: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ctl_r[1].run && ctl_r[1].mode == tte_pkg::TTE_MODE_EVENT && evt[1] && !hi_wr[1]
     && count_r[1] != tte_pkg::TTE_COUNT_FULL) |=> (count_r[1] == $past(count_r[1]) + 16'h0001))
    else $error("event did not add one");

  // the same guards carried over to the other timers, plus mode and bus gating
  a_ovf1_irq: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ovf[1]) |=> irq_o[1])
    else $error("timer 1 overflow gave no request");

  a_ovf2_irq: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ovf[2]) |=> irq_o[2])
    else $error("timer 2 overflow gave no request");

  a_irq_cause0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !ovf[0]) |=> !irq_o[0])
    else $error("timer 0 request without overflow");

  a_irq_cause1: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !ovf[1]) |=> !irq_o[1])
    else $error("timer 1 request without overflow");

  a_irq_cause2: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && !ovf[2]) |=> !irq_o[2])
    else $error("timer 2 request without overflow");

  a_ovf1_reload: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ovf[1] && !hi_wr[1]) |=> (count_r[1] == $past(preload_r[1])))
    else $error("timer 1 overflow did not reload");

  a_ovf2_reload: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ovf[2] && !hi_wr[2]) |=> (count_r[2] == $past(preload_r[2])))
    else $error("timer 2 overflow did not reload");

  a_run_hi_keep0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (hi_wr[0] && ctl_r[0].run && !tick[0]) |=> $stable(count_r[0]))
    else $error("timer 0 running high write changed the count");

  a_run_hi_keep1: assert property (@(posedge mclk_i) disable iff (reset_i)
    (hi_wr[1] && ctl_r[1].run && !tick[1]) |=> $stable(count_r[1]))
    else $error("timer 1 running high write changed the count");

  a_run_hi_step2: assert property (@(posedge mclk_i) disable iff (reset_i)
    (hi_wr[2] && ctl_r[2].run && tick[2] && !ovf[2])
      |=> (count_r[2] == $past(count_r[2]) + 16'h0001))
    else $error("timer 2 running high write disturbed the count");

  a_lo_wr_keep0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (lo_wr[0] && !tick[0]) |=> ($stable(count_r[0]) && hold_r[0] == $past(wbyte)))
    else $error("timer 0 low write reached the count");

  a_lo_wr_keep2: assert property (@(posedge mclk_i) disable iff (reset_i)
    (lo_wr[2] && !ctl_r[2].run) |=> ($stable(count_r[2]) && hold_r[2] == $past(wbyte)))
    else $error("timer 2 low write reached the count");

  a_hi_wr_pre0: assert property (@(posedge mclk_i) disable iff (reset_i)
    hi_wr[0] |=> (preload_r[0] == {$past(wbyte), $past(hold_r[0])}))
    else $error("timer 0 high write missed the preload");

  a_hi_wr_pre1: assert property (@(posedge mclk_i) disable iff (reset_i)
    hi_wr[1] |=> (preload_r[1] == {$past(wbyte), $past(hold_r[1])}))
    else $error("timer 1 high write missed the preload");

  a_hi_wr_pre2: assert property (@(posedge mclk_i) disable iff (reset_i)
    hi_wr[2] |=> (preload_r[2] == {$past(wbyte), $past(hold_r[2])}))
    else $error("timer 2 high write missed the preload");

  a_t2_timer_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[2].mode != tte_pkg::TTE_MODE_TIMER) |-> !tick[2])
    else $error("timer 2 counted outside timer mode");

  a_t2_no_edge: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!ctl_r[2].edge_sel && ctl_r[2].rsv == 3'h0))
    else $error("timer 2 kept edge or low control bits");

  a_t0_prescale: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[0].run && ctl_r[0].mode == tte_pkg::TTE_MODE_TIMER) |-> (tick[0] == pre_tick))
    else $error("timer 0 tick off the divided clock");

  a_t1_lf_tick: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[1].run && ctl_r[1].mode == tte_pkg::TTE_MODE_TIMER) |-> (tick[1] == lf_rise))
    else $error("timer 1 tick off the low-frequency clock");

  a_off_idle0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[0].mode == tte_pkg::TTE_MODE_OFF) |-> !tick[0])
    else $error("timer 0 counted in the idle mode");

  a_off_idle1: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[1].mode == tte_pkg::TTE_MODE_OFF) |-> !tick[1])
    else $error("timer 1 counted in the idle mode");

  a_stop_idle0: assert property (@(posedge mclk_i) disable iff (reset_i)
    !ctl_r[0].run |-> !tick[0])
    else $error("timer 0 counted while stopped");

  a_stop_idle1: assert property (@(posedge mclk_i) disable iff (reset_i)
    !ctl_r[1].run |-> !tick[1])
    else $error("timer 1 counted while stopped");

  a_event_step0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ctl_r[0].run && ctl_r[0].mode == tte_pkg::TTE_MODE_EVENT && evt[0] && !hi_wr[0]
     && count_r[0] != tte_pkg::TTE_COUNT_FULL) |=> (count_r[0] == $past(count_r[0]) + 16'h0001))
    else $error("timer 0 event did not add one");

  a_event_edge0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[0].mode == tte_pkg::TTE_MODE_EVENT && !evt[0]) |-> !tick[0])
    else $error("timer 0 counted without a selected edge");

  a_event_edge1: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[1].mode == tte_pkg::TTE_MODE_EVENT && !evt[1]) |-> !tick[1])
    else $error("timer 1 counted without a selected edge");

  a_pwm1_autoclr: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && meas_r[1] && pwm_end[1] && !ctl_wr[1]) |=> (!ctl_r[1].run && !meas_r[1]))
    else $error("timer 1 pulse end did not stop the timer");

  a_pwm_gate0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ctl_r[0].mode == tte_pkg::TTE_MODE_PWM && !meas_r[0]) |-> !tick[0])
    else $error("timer 0 counted outside the measured pulse");

  a_pwm_start0: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && ctl_r[0].run && ctl_r[0].mode == tte_pkg::TTE_MODE_PWM && !meas_r[0]
     && pwm_start[0] && !ctl_wr[0]) |=> meas_r[0])
    else $error("timer 0 missed the pulse start");

  a_high_rd_cap1: assert property (@(posedge mclk_i) disable iff (reset_i)
    hi_rd[1] |=> (hold_r[1] == $past(count_r[1][7:0])))
    else $error("timer 1 high read did not capture the low byte");

  a_high_rd_cap2: assert property (@(posedge mclk_i) disable iff (reset_i)
    hi_rd[2] |=> (hold_r[2] == $past(count_r[2][7:0])))
    else $error("timer 2 high read did not capture the low byte");

  a_off_copy2: assert property (@(posedge mclk_i) disable iff (reset_i)
    (hi_wr[2] && !ctl_r[2].run) |=> (count_r[2] == {$past(wbyte), $past(hold_r[2])}))
    else $error("timer 2 stopped preload write missed the count");

  a_up_only1: assert property (@(posedge mclk_i) disable iff (reset_i)
    (ce_i && tick[1] && !ovf[1] && !hi_wr[1])
      |=> (count_r[1] == $past(count_r[1]) + 16'h0001))
    else $error("timer 1 did not count up by one");

  a_full_ovf2: assert property (@(posedge mclk_i) disable iff (reset_i)
    (tick[2] && count_r[2] == tte_pkg::TTE_COUNT_FULL) |-> ovf[2])
    else $error("timer 2 passed full count without overflow");

  a_mode_field0: assert property (@(posedge mclk_i) disable iff (reset_i)
    ctl_wr[0] |=> (ctl_r[0].mode == $past(wbyte[7:6])))
    else $error("timer 0 mode field not taken from bits 7:6");

  a_mode_field1: assert property (@(posedge mclk_i) disable iff (reset_i)
    ctl_wr[1] |=> (ctl_r[1].mode == $past(wbyte[7:6])))
    else $error("timer 1 mode field not taken from bits 7:6");

  a_run_bit2: assert property (@(posedge mclk_i) disable iff (reset_i)
    ctl_wr[2] |=> (ctl_r[2].run == $past(wbyte[4])))
    else $error("timer 2 run bit not taken from bit 4");
endmodule
`default_nettype wire
